/* File: pkg/sleep_pkg.sv */
// Purpose: Shared constants and types for the radio sleep controller
// Assumes: 200 MHz clock, AHB-Lite register access, 32-bit data
// Notes: Timer registers count clock cycles
package sleep_pkg;
	// Clock and wake latency, typical figures
	localparam int CLK_PERIOD_NS = 5;
	localparam int WAKE_HIB_NS = 10200000;
	localparam int WAKE_DOZE_NS = 2600000;
	localparam int WAKE_HIB_CYC = WAKE_HIB_NS / CLK_PERIOD_NS;
	localparam int WAKE_DOZE_CYC = WAKE_DOZE_NS / CLK_PERIOD_NS;

	// Sleep mode selections
	localparam logic [2:0] MODE_NONE = 3'h0;
	localparam logic [2:0] MODE_PIN_HIB = 3'h1;
	localparam logic [2:0] MODE_PIN_DOZE = 3'h2;
	localparam logic [2:0] MODE_CYC = 3'h4;
	localparam logic [2:0] MODE_CYC_PIN = 3'h5;
	localparam logic [2:0] MODE_COORD = 3'h6;

	// Register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_PERIOD = 8'h04;
	localparam logic [7:0] OFF_IDLE = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_MSG_LO = 8'h10;
	localparam logic [7:0] OFF_MSG_HI = 8'h14;
	localparam logic [7:0] OFF_MSG_POST = 8'h18;

	// Reset values and field positions
	localparam logic [31:0] PERIOD_RST = 32'h0000_1000;
	localparam logic [31:0] IDLE_RST = 32'h0000_0800;
	localparam int STAT_CTS_BIT = 4;
	localparam int STAT_ASLEEP_BIT = 5;
	localparam int STAT_MSG_BIT = 6;
	localparam int POST_LONG_BIT = 0;
	localparam int SHORT_ADDR_W = 16;
	localparam int HTRANS_ACTIVE_BIT = 1;

	typedef enum logic [2:0] {
		AWAKE = 3'h0,
		DRAIN = 3'h1,
		SLEEP = 3'h3,
		WAKE = 3'h2,
		POLL = 3'h6
	} state_type;

	// Captured AHB address phase
	typedef struct packed {
		logic act;
		logic wr;
		logic [ADDR_W-1:0] addr;
	} ahb_phase_type;

	function automatic logic is_pin_mode(input logic [2:0] m);
		return (m == MODE_PIN_HIB) || (m == MODE_PIN_DOZE);
	endfunction

	function automatic logic is_cyc_mode(input logic [2:0] m);
		return (m == MODE_CYC) || (m == MODE_CYC_PIN);
	endfunction
endpackage

/* File: verilog/radio_sleep_ctrl.sv */
// Purpose: Sleep state controller for a low-power radio module
// Assumes: busy/activity/poll inputs come from logic on clk_i
// Notes: Registers over AHB-Lite, zero wait states, always OKAY
// How it works
// (R1) Pin sleep waits for busy work, then sleeps
// (R2) Asleep under pin mode: ignore serial, radio
// (R3) Pin release wakes, then CTS driven low
// (R4) Host waits two characters after CTS falls
// (R5) Hibernate wake takes about 10.2 ms
// (R6) Doze like hibernate, wake about 2.6 ms
// (R7) Cyclic remote wakes each period, sends poll
// (R8) Empty poll answer: back to sleep
// (R9) Poll data: stay awake until idle expiry
// (R10) Cyclic remote drives CTS low each wake
// (R11) Mode five also wakes on pin fall
// (R12) Activity restarts idle timer before sleeping
// (R13) After pin wake, ignore pin; idle only
// (R14) Coordinator always awake, buffers one message
// (R15) Matching poll sends the buffered message
// (R16) At most one buffered indirect message
// (R17) Drop message after 2.5 sleep periods
// (R18) Coordinator period should match remote period
// (R19) Idle timer used only in cyclic modes
// (R20) Mode zero never sleeps
// (R21) CTS high while asleep and waking
// (R22) Sleep request pin synchronised before use
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module radio_sleep_ctrl #(
	parameter int WAKE_HIB_CYC = sleep_pkg::WAKE_HIB_CYC,
	parameter int WAKE_DOZE_CYC = sleep_pkg::WAKE_DOZE_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Host pins
	input wire logic sleep_request_pin_i,
	output logic cts_n_o,
	// Radio and serial core
	input wire logic busy_i,
	input wire logic activity_i,
	input wire logic poll_data_i,
	input wire logic poll_empty_i,
	input wire logic poll_in_valid_i,
	input wire logic [63:0] poll_in_addr_i,
	output logic asleep_o,
	output logic traffic_en_o,
	output logic poll_req_o,
	output logic msg_send_o
);
	logic rst_meta_reg, rst_n;
	logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
	sleep_pkg::ahb_phase_type dp_reg;
	logic [2:0] mode_reg;
	logic [31:0] period_reg, idle_reg, tmr_reg, wake_cyc;
	logic [63:0] msg_addr_reg;
	logic msg_long_reg, msg_valid_reg;
	logic [33:0] age_reg, hold_lim;
	sleep_pkg::state_type state_reg, state_next;
	logic poll_cause_reg, cts_n_reg, asleep_reg, traffic_en_reg;
	logic poll_req_reg, msg_send_reg, pin_fall, pin_mode, cyc_mode;
	logic addr_ok, wr_now, post, match, discard;
	logic [31:0] rdata;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// Only the second stage feeds level and edge logic
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else begin
			pin_meta_reg <= sleep_request_pin_i; // R22
			pin_sync_reg <= pin_meta_reg; // R22
			pin_prev_reg <= pin_sync_reg;
		end
	end
	assign pin_fall = pin_prev_reg & ~pin_sync_reg; // R11

	assign pin_mode = sleep_pkg::is_pin_mode(mode_reg);
	assign cyc_mode = sleep_pkg::is_cyc_mode(mode_reg);

	// Bus slave: read data is latched in the address phase
	assign addr_ok = (haddr_i[31:sleep_pkg::ADDR_W] == '0);
	always_comb begin
		rdata = 32'h0000_0000;
		unique case (haddr_i[sleep_pkg::ADDR_W-1:0])
			sleep_pkg::OFF_MODE: rdata = {29'h0000_0000, mode_reg};
			sleep_pkg::OFF_PERIOD: rdata = period_reg;
			sleep_pkg::OFF_IDLE: rdata = idle_reg;
			sleep_pkg::OFF_STATUS: begin
				rdata[2:0] = state_reg;
				rdata[sleep_pkg::STAT_CTS_BIT] = cts_n_reg;
				rdata[sleep_pkg::STAT_ASLEEP_BIT] = asleep_reg;
				rdata[sleep_pkg::STAT_MSG_BIT] = msg_valid_reg;
			end
			sleep_pkg::OFF_MSG_LO: rdata = msg_addr_reg[31:0];
			sleep_pkg::OFF_MSG_HI: rdata = msg_addr_reg[63:32];
			default: rdata = 32'h0000_0000;
		endcase
		if (!addr_ok) begin
			rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dp_reg <= '0;
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else if (hready_i) begin
			dp_reg.act <= hsel_i & htrans_i[sleep_pkg::HTRANS_ACTIVE_BIT]
				& addr_ok;
			dp_reg.wr <= hwrite_i;
			dp_reg.addr <= haddr_i[sleep_pkg::ADDR_W-1:0];
			hrdata_o <= rdata;
		end
	end

	assign wr_now = dp_reg.act & dp_reg.wr;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= sleep_pkg::MODE_NONE;
			period_reg <= sleep_pkg::PERIOD_RST;
			idle_reg <= sleep_pkg::IDLE_RST;
		end else if (wr_now) begin
			if (dp_reg.addr == sleep_pkg::OFF_MODE) begin
				mode_reg <= hwdata_i[2:0];
			end
			if (dp_reg.addr == sleep_pkg::OFF_PERIOD) begin
				period_reg <= hwdata_i;
			end
			if (dp_reg.addr == sleep_pkg::OFF_IDLE) begin
				idle_reg <= hwdata_i;
			end
		end
	end

	// Doze latency also serves the cyclic modes
	assign wake_cyc = (mode_reg == sleep_pkg::MODE_PIN_HIB) ?
		32'(WAKE_HIB_CYC) : 32'(WAKE_DOZE_CYC); // R5 R6

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			sleep_pkg::AWAKE: begin
				if (pin_mode && pin_sync_reg) begin
					state_next = sleep_pkg::DRAIN; // R1
				end else if (cyc_mode && tmr_reg >= idle_reg) begin
					state_next = sleep_pkg::DRAIN; // R9 R12 R13 R19
				end
			end
			sleep_pkg::DRAIN: begin
				if (pin_mode && !pin_sync_reg) begin
					state_next = sleep_pkg::AWAKE;
				end else if (!pin_mode && !cyc_mode) begin
					state_next = sleep_pkg::AWAKE; // R20
				end else if (!busy_i) begin
					state_next = sleep_pkg::SLEEP; // R1
				end
			end
			sleep_pkg::SLEEP: begin
				if (pin_mode) begin
					if (!pin_sync_reg) begin
						state_next = sleep_pkg::WAKE; // R3
					end
				end else if (cyc_mode) begin
					if (tmr_reg >= period_reg) begin
						state_next = sleep_pkg::WAKE; // R7
					end else if (mode_reg == sleep_pkg::MODE_CYC_PIN
						&& pin_fall) begin
						state_next = sleep_pkg::WAKE; // R11
					end
				end else begin
					state_next = sleep_pkg::AWAKE; // R14 R20
				end
			end
			sleep_pkg::WAKE: begin
				if (tmr_reg >= wake_cyc) begin
					state_next = poll_cause_reg ? sleep_pkg::POLL :
						sleep_pkg::AWAKE;
				end
			end
			sleep_pkg::POLL: begin
				if (poll_data_i) begin
					state_next = sleep_pkg::AWAKE; // R9
				end else if (poll_empty_i || tmr_reg >= idle_reg) begin
					state_next = sleep_pkg::DRAIN; // R8
				end
			end
			default: state_next = sleep_pkg::AWAKE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= sleep_pkg::AWAKE;
			poll_cause_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == sleep_pkg::SLEEP) begin
				poll_cause_reg <= cyc_mode && tmr_reg >= period_reg;
			end
		end
	end

	// One shared timer, cleared on each state change: period, wake latency or idle time
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tmr_reg <= 32'h0000_0000;
		end else if (state_next != state_reg) begin
			tmr_reg <= 32'h0000_0000;
		end else if (activity_i && state_reg == sleep_pkg::AWAKE) begin
			tmr_reg <= 32'h0000_0000; // R12
		end else begin
			tmr_reg <= tmr_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cts_n_reg <= 1'b1;
			asleep_reg <= 1'b0;
			traffic_en_reg <= 1'b1;
			poll_req_reg <= 1'b0;
		end else begin
			cts_n_reg <= !(state_next == sleep_pkg::AWAKE ||
				state_next == sleep_pkg::POLL); // R3 R10 R21
			asleep_reg <= state_next == sleep_pkg::SLEEP;
			traffic_en_reg <= state_next != sleep_pkg::SLEEP; // R2
			poll_req_reg <= state_reg == sleep_pkg::WAKE &&
				state_next == sleep_pkg::POLL; // R7
		end
	end

	// Coordinator indirect message slot
	assign post = wr_now && dp_reg.addr == sleep_pkg::OFF_MSG_POST &&
		mode_reg == sleep_pkg::MODE_COORD;
	assign match = msg_valid_reg && poll_in_valid_i && (msg_long_reg ?
		poll_in_addr_i == msg_addr_reg :
		poll_in_addr_i[sleep_pkg::SHORT_ADDR_W-1:0] ==
		msg_addr_reg[sleep_pkg::SHORT_ADDR_W-1:0]);
	assign hold_lim = {1'b0, period_reg, 1'b0} +
		{3'b000, period_reg[31:1]};
	assign discard = msg_valid_reg && age_reg >= hold_lim; // R17

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			msg_addr_reg <= 64'h0000_0000_0000_0000;
			msg_long_reg <= 1'b0;
			msg_valid_reg <= 1'b0;
			age_reg <= 34'h0_0000_0000;
			msg_send_reg <= 1'b0;
		end else begin
			msg_send_reg <= match; // R15
			age_reg <= msg_valid_reg ? age_reg + 34'h0_0000_0001 :
				34'h0_0000_0000;
			// Address is frozen while a message waits
			if (wr_now && !msg_valid_reg) begin
				if (dp_reg.addr == sleep_pkg::OFF_MSG_LO) begin
					msg_addr_reg[31:0] <= hwdata_i; // R16
				end
				if (dp_reg.addr == sleep_pkg::OFF_MSG_HI) begin
					msg_addr_reg[63:32] <= hwdata_i; // R16
				end
			end
			if (post && !msg_valid_reg) begin
				msg_valid_reg <= 1'b1; // R14 R16
				msg_long_reg <= hwdata_i[sleep_pkg::POST_LONG_BIT];
			end else if (match || discard ||
				mode_reg != sleep_pkg::MODE_COORD) begin
				msg_valid_reg <= 1'b0; // R15 R17
			end
		end
	end

	assign cts_n_o = cts_n_reg;
	assign asleep_o = asleep_reg;
	assign traffic_en_o = traffic_en_reg;
	assign poll_req_o = poll_req_reg;
	assign msg_send_o = msg_send_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	sequence s_woken;
		state_reg == sleep_pkg::WAKE ##1 state_reg == sleep_pkg::POLL;
	endsequence
	property p_drain_busy; // R1
		state_reg == sleep_pkg::DRAIN && busy_i && pin_sync_reg
			|=> state_reg != sleep_pkg::SLEEP;
	endproperty
	a_drain_busy: assert property (p_drain_busy) else $error("slept busy"); // R1
	property p_deaf; // R2
		state_reg == sleep_pkg::SLEEP |-> !traffic_en_o && cts_n_o;
	endproperty
	a_deaf: assert property (p_deaf) else $error("traffic while asleep"); // R2
	property p_pin_wake; // R3
		pin_mode && state_reg == sleep_pkg::SLEEP && !pin_sync_reg
			|=> state_reg == sleep_pkg::WAKE;
	endproperty
	a_pin_wake: assert property (p_pin_wake) else $error("no pin wake"); // R3
	property p_poll_req; // R7
		s_woken |-> poll_req_o ##1 !poll_req_o;
	endproperty
	a_poll_req: assert property (p_poll_req) else $error("poll pulse"); // R7
	property p_empty; // R8
		state_reg == sleep_pkg::POLL && !poll_data_i && poll_empty_i
			|=> state_reg == sleep_pkg::DRAIN;
	endproperty
	a_empty: assert property (p_empty) else $error("empty poll"); // R8
	property p_idle; // R12
		activity_i && state_reg == sleep_pkg::AWAKE &&
			state_next == sleep_pkg::AWAKE |=> tmr_reg == 32'h0000_0000;
	endproperty
	a_idle: assert property (p_idle) else $error("idle not restarted"); // R12
	// Leaving coordinator mode empties the slot on purpose
	property p_one_msg; // R16
		msg_valid_reg && !match && !discard &&
			mode_reg == sleep_pkg::MODE_COORD |=> $stable(msg_addr_reg)
			&& msg_valid_reg;
	endproperty
	a_one_msg: assert property (p_one_msg) else $error("slot overwritten"); // R16
	property p_mode0; // R20
		mode_reg == sleep_pkg::MODE_NONE && state_reg == sleep_pkg::AWAKE
			|=> state_reg == sleep_pkg::AWAKE;
	endproperty
	a_mode0: assert property (p_mode0) else $error("mode zero slept"); // R20
	property p_cts_high; // R21
		state_reg == sleep_pkg::WAKE |-> cts_n_o;
	endproperty
	a_cts_high: assert property (p_cts_high) else $error("cts low waking"); // R21
endmodule

/* File: tb/host_model.sv */
// Purpose: Host processor model on the sleep pin and CTS
// Assumes: Character time is given in clock cycles
// Notes: Data may go out only after the CTS settle margin
`timescale 1ns/1ps
module host_model #(
	parameter int CHAR_CYC = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Bench side
	input wire logic want_sleep_i,
	output logic tx_ok_o,
	// Module pins
	input wire logic cts_n_i,
	output logic sleep_request_pin_o
);
	int ready_cnt;

	// Port register: pin moves just after the edge
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sleep_request_pin_o <= 1'b0;
		end else begin
			sleep_request_pin_o <= want_sleep_i;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ready_cnt <= 0;
		end else if (cts_n_i) begin
			ready_cnt <= 0;
		end else if (ready_cnt < 2 * CHAR_CYC) begin
			ready_cnt <= ready_cnt + 1;
		end
	end

	// Two characters after CTS falls, so data reaches the input buffer
	assign tx_ok_o = !cts_n_i && (ready_cnt >= 2 * CHAR_CYC);
endmodule

/* File: tb/radio_module_sleep_control_tb.sv */
// Purpose: Self-checking bench for the radio sleep controller
// Assumes: Wake counts shortened to 20 and 8 cycles
// Notes: Cycle windows allow for the pin synchroniser
`timescale 1ns/1ps
module radio_module_sleep_control_tb;
	localparam int HIB = 20;
	localparam int DOZE = 8;
	logic clk_i, arst_n_i, hsel, hwrite, hready, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic pin, cts_n, busy, activity, poll_data, poll_empty;
	logic poll_in_valid, asleep, traffic_en, poll_req, msg_send;
	logic want_sleep, tx_ok;
	logic [63:0] poll_in_addr;
	int fail_count, num_checks, n;

	radio_sleep_ctrl #(.WAKE_HIB_CYC(HIB), .WAKE_DOZE_CYC(DOZE))
	radio_sleep_ctrl_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
		.hresp_o(hresp), .sleep_request_pin_i(pin), .cts_n_o(cts_n),
		.busy_i(busy), .activity_i(activity), .poll_data_i(poll_data),
		.poll_empty_i(poll_empty), .poll_in_valid_i(poll_in_valid),
		.poll_in_addr_i(poll_in_addr), .asleep_o(asleep),
		.traffic_en_o(traffic_en), .poll_req_o(poll_req),
		.msg_send_o(msg_send));

	host_model #(.CHAR_CYC(4)) host_model_inst (.clk_i(clk_i),
		.arst_n_i(arst_n_i), .want_sleep_i(want_sleep), .tx_ok_o(tx_ok),
		.cts_n_i(cts_n), .sleep_request_pin_o(pin));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] q);
		num_checks++;
		if (q !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, q);
		end
	endtask

	task automatic check_rng(input string nm, input int lo, input int hi,
		input int q);
		num_checks++;
		if (q < lo || q > hi) begin
			fail_count++;
			$display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, q);
		end
	endtask

	// Waits are bounded; n returns the cycles spent
	task automatic wait_sig(input int s, input logic v, input int mx);
		n = 0;
		while ((s == 0 ? cts_n : s == 1 ? asleep : s == 2 ? poll_req :
			s == 3 ? msg_send : tx_ok) !== v && n < mx) begin
			@(negedge clk_i);
			n++;
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk_i); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, {24'h0, a}, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		logic [31:0] q;
		ahb(1'b0, {24'h0, a}, 32'h0, q);
		check(nm, e, q);
	endtask

	task automatic pulse(input int s);
		@(posedge clk_i);
		if (s == 0) activity <= 1'b1;
		if (s == 1) poll_data <= 1'b1;
		if (s == 2) poll_empty <= 1'b1;
		if (s == 3) poll_in_valid <= 1'b1;
		@(posedge clk_i);
		{activity, poll_data, poll_empty, poll_in_valid} <= 4'h0;
	endtask

	task automatic test_reset;
		logic [31:0] q;
		rd(sleep_pkg::OFF_MODE, 32'h0, "mode");
		rd(sleep_pkg::OFF_PERIOD, sleep_pkg::PERIOD_RST, "period");
		rd(sleep_pkg::OFF_IDLE, sleep_pkg::IDLE_RST, "idle");
		ahb(1'b0, 32'h0000_0100, 32'h0, q);
		check("unmapped", 32'h0, q);
		wr(sleep_pkg::OFF_IDLE, 32'h0000_001E);
		want_sleep <= 1'b1;
		repeat (60) @(negedge clk_i);
		check("mode0 asleep", 32'h0, asleep);
		check("mode0 cts", 32'h0, cts_n);
		want_sleep <= 1'b0;
	endtask

	task automatic test_pin;
		for (int m = 1; m <= 2; m++) begin
			wr(sleep_pkg::OFF_MODE, m[31:0]);
			busy <= 1'b1;
			want_sleep <= 1'b1;
			wait_sig(0, 1'b1, 50);
			check_rng("pin to cts high", 4, 6, n);
			repeat (10) @(negedge clk_i);
			check("asleep while busy", 32'h0, asleep);
			@(posedge clk_i);
			busy <= 1'b0;
			wait_sig(1, 1'b1, 50);
			check_rng("drain to sleep", 1, 3, n);
			pulse(0);
			pulse(1);
			repeat (4) @(negedge clk_i);
			check("traffic off", 32'h0, traffic_en);
			check("cts asleep", 32'h1, cts_n);
			want_sleep <= 1'b0;
			wait_sig(0, 1'b0, 200);
			check_rng("wake time", (m == 1 ? HIB : DOZE) + 4,
				(m == 1 ? HIB : DOZE) + 8, n);
		end
	endtask

	task automatic test_cyclic;
		wr(sleep_pkg::OFF_PERIOD, 32'h0000_0032);
		wr(sleep_pkg::OFF_MODE, 32'h0000_0004);
		// Idle timer runs since the last wake; restart it at a known edge
		pulse(0);
		wait_sig(1, 1'b1, 100);
		check_rng("idle to sleep", 28, 36, n);
		wait_sig(2, 1'b1, 200);
		check_rng("period wake", 56, 66, n);
		check("cts at wake", 32'h0, cts_n);
		pulse(2);
		wait_sig(1, 1'b1, 20);
		check_rng("empty poll", 0, 4, n);
		wait_sig(2, 1'b1, 200);
		pulse(1);
		wait_sig(4, 1'b1, 50);
		check_rng("host margin", 6, 8, n);
		for (int i = 0; i < 3; i++) begin
			pulse(0);
			repeat (20) @(negedge clk_i);
			check("awake after data", 32'h0, asleep);
		end
		wait_sig(1, 1'b1, 100);
		check_rng("idle after data", 8, 16, n);
	endtask

	task automatic test_cyc_pin;
		wr(sleep_pkg::OFF_PERIOD, 32'h0000_0190);
		wr(sleep_pkg::OFF_MODE, 32'h0000_0005);
		wait_sig(1, 1'b1, 100);
		want_sleep <= 1'b1;
		repeat (10) @(negedge clk_i);
		check("rise ignored", 32'h1, asleep);
		want_sleep <= 1'b0;
		wait_sig(0, 1'b0, 100);
		check_rng("pin fall wake", DOZE + 4, DOZE + 9, n);
		want_sleep <= 1'b1;
		repeat (10) @(negedge clk_i);
		check("pin after wake", 32'h0, cts_n);
		want_sleep <= 1'b0;
		wait_sig(1, 1'b1, 100);
		check_rng("sleep on idle", 15, 26, n);
	endtask

	task automatic test_coord;
		wr(sleep_pkg::OFF_PERIOD, 32'h0000_0028);
		wr(sleep_pkg::OFF_MODE, 32'h0000_0006);
		wr(sleep_pkg::OFF_MSG_LO, 32'h0000_1234);
		wr(sleep_pkg::OFF_MSG_POST, 32'h0);
		rd(sleep_pkg::OFF_STATUS, 32'h0000_0040, "held");
		wr(sleep_pkg::OFF_MSG_LO, 32'h0000_5678);
		rd(sleep_pkg::OFF_MSG_LO, 32'h0000_1234, "one slot");
		poll_in_addr <= 64'h1235;
		pulse(3);
		wait_sig(3, 1'b1, 6);
		check_rng("other remote", 6, 6, n);
		@(posedge clk_i);
		poll_in_addr <= 64'h1234;
		pulse(3);
		wait_sig(3, 1'b1, 6);
		check_rng("send", 0, 2, n);
		rd(sleep_pkg::OFF_STATUS, 32'h0, "slot freed");
		wr(sleep_pkg::OFF_MSG_LO, 32'h89AB_CDEF);
		wr(sleep_pkg::OFF_MSG_HI, 32'h0123_4567);
		wr(sleep_pkg::OFF_MSG_POST, 32'h1);
		poll_in_addr <= 64'h0000_0000_89AB_CDEF;
		pulse(3);
		repeat (85) @(negedge clk_i);
		rd(sleep_pkg::OFF_STATUS, 32'h0000_0040, "kept");
		repeat (12) @(negedge clk_i);
		rd(sleep_pkg::OFF_STATUS, 32'h0, "dropped");
		check("coord awake", 32'h0, asleep);
		check("okay", 32'h0, hresp);
	endtask

	initial begin
		arst_n_i = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		{want_sleep, busy, activity, poll_data, poll_empty} = '0;
		poll_in_valid = 1'b0;
		poll_in_addr = 64'h0;
		repeat (6) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		test_reset;
		test_pin;
		test_cyclic;
		test_cyc_pin;
		test_coord;
		test_done;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		$display("mismatch timeout expected done seen hang");
		test_done;
	end
endmodule
